// ===== sync_input_pkg.sv
package sync_input_pkg;

  // Register map (word addresses on the Avalon bus)
  localparam logic [1:0] ctrl_addr         = 2'h0;
  localparam logic [1:0] rise_capture_addr = 2'h1;
  localparam logic [1:0] fall_capture_addr = 2'h2;
  localparam logic [1:0] status_addr       = 2'h3;

  // Control register field positions
  localparam int mode_hi_bit    = 7;
  localparam int mode_lo_bit    = 6;
  localparam int conn_en_bit    = 5;
  localparam int cap_start_bit  = 4;
  localparam int inv_field_msb  = 3;

  localparam logic [7:0] ctrl_reset   = 8'h00;
  localparam logic [7:0] capture_zero = 8'h00;
  localparam logic [31:0] unmapped_rd = 32'h0000_0000;

  typedef enum logic [1:0] {
    mode_none      = 2'b00,
    mode_sync_on_g = 2'b01,
    mode_composite = 2'b10,
    mode_separate  = 2'b11
  } sync_mode_t;

  typedef enum logic [1:0] {
    cap_idle      = 2'b00,
    cap_wait_rise = 2'b01,
    cap_wait_fall = 2'b10
  } cap_state_t;

  // External sync pins
  typedef struct packed {
    logic horiz_sync_input;
    logic vert_sync_input;
    logic composite_sync_input;
    logic spare_horiz_input;
    logic spare_vert_input;
    logic separated_vert_source;
  } sync_pins_t;

  // Normal pin inputs of the timers
  typedef struct packed {
    logic frt_a;
    logic frt_b;
    logic frt_c;
    logic frt_d;
    logic chan1_event_input;
    logic chan_x_event_input;
    logic chan_y_event_input;
  } timer_pins_t;

  // Inputs as seen by the timers
  typedef struct packed {
    logic frt_a;
    logic frt_b;
    logic frt_c;
    logic frt_d;
    logic chan1_clock;
    logic chan1_reset;
    logic chan_x_clock;
    logic chan_x_reset;
    logic chan_y_clock;
    logic chan_y_reset;
  } timer_feed_t;

endpackage

// ===== pulse_capture.sv
`timescale 1ns/1ps
module pulse_capture
  import sync_input_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Control
  input  wire logic       arm,
  input  wire logic       reset_in,
  input  wire logic [7:0] timer_count_value,
  // Results
  output logic            busy_q,
  output logic [7:0]      rise_capture_q,
  output logic [7:0]      fall_capture_q
);

  cap_state_t state_q;
  logic       prev_q;
  logic       rise;
  logic       fall;

  assign rise = reset_in & ~prev_q;
  assign fall = ~reset_in & prev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= reset_in;
    end
  end

  // Single armed pass: rise, then fall, then disarm
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= cap_idle;
    end else if (clk_en) begin
      unique case (state_q)
        cap_idle: begin
          if (arm) state_q <= cap_wait_rise;
        end
        cap_wait_rise: begin
          if (rise) state_q <= cap_wait_fall;
        end
        cap_wait_fall: begin
          if (fall) state_q <= cap_idle;
        end
        default: state_q <= cap_idle;
      endcase
    end
  end

  // Captures only while armed; idle edges change nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_capture_q <= capture_zero;
      fall_capture_q <= capture_zero;
    end else if (clk_en) begin
      if (state_q == cap_wait_rise && rise) rise_capture_q <= timer_count_value;
      if (state_q == cap_wait_fall && fall) fall_capture_q <= timer_count_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (arm) busy_q <= 1'b1;
      else if (state_q == cap_wait_fall && fall) busy_q <= 1'b0;
    end
  end

endmodule

// ===== sync_input_select_capture.sv
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Operation
// - Two-bit sync mode at bits 7:6, reset zero; none, SoG, composite, separate.
// - Internal horizontal: 00 spare horizontal, 01 composite, 1x horizontal input.
// - Internal vertical: 00 spare vertical, 01/10 separated source, 11 vertical input.
// - Bit 5 connection enable, reset zero, selects timer input sources.
// - Enable zero feeds each timer input from its own pin.
// - Enable one feeds timers from internal sync signals per fixed table.
// - With enable one, channel X reset input is the internal horizontal sync.
// - Once armed, rising edge captures count to rise reg, falling to fall reg.
// - Hardware clears capture-start after both edges are captured.
// - Capture-start sets only on a write of one after reading it zero.
// - One armed operation yields both pulse edge timestamps.
module sync_input_select_capture
  import sync_input_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Pins and timer side
  input  wire sync_pins_t  sync_pins,
  input  wire timer_pins_t timer_pins,
  input  wire logic        chan1_compare_output,
  input  wire logic        generated_vert_sync,
  input  wire logic [7:0]  timer_count_value,
  // Outputs
  output timer_feed_t      timer_feed_q,
  output logic             internal_horiz_sync_q,
  output logic             internal_vert_sync_q
);

  logic [7:0] ctrl_q;
  logic       read_zero_q;
  logic       ack_q;
  logic       busy;
  logic [7:0] rise_cap;
  logic [7:0] fall_cap;
  logic       internal_horiz_sync;
  logic       internal_vert_sync;
  logic       arm;
  logic       req;
  logic       wr_ctrl;
  logic       rd_ctrl;
  sync_mode_t mode;
  timer_feed_t feed_d;

  assign mode    = sync_mode_t'(ctrl_q[mode_hi_bit:mode_lo_bit]);
  assign req     = (avs_read | avs_write) & ~ack_q & clk_en;
  assign wr_ctrl = req & avs_write & (avs_address == ctrl_addr);
  assign rd_ctrl = req & avs_read & (avs_address == ctrl_addr);
  assign arm     = wr_ctrl & avs_writedata[cap_start_bit] & read_zero_q & ~busy;

  always_comb begin
    unique case (mode)
      mode_none:      internal_horiz_sync = sync_pins.spare_horiz_input;
      mode_sync_on_g: internal_horiz_sync = sync_pins.composite_sync_input;
      default:        internal_horiz_sync = sync_pins.horiz_sync_input;
    endcase
  end

  always_comb begin
    unique case (mode)
      mode_none:      internal_vert_sync = sync_pins.spare_vert_input;
      mode_separate:  internal_vert_sync = sync_pins.vert_sync_input;
      default:        internal_vert_sync = sync_pins.separated_vert_source;
    endcase
  end

  always_comb begin
    if (ctrl_q[conn_en_bit]) begin
      feed_d.frt_a        = internal_vert_sync;
      feed_d.frt_b        = chan1_compare_output;
      feed_d.frt_c        = sync_pins.spare_vert_input;
      feed_d.frt_d        = internal_horiz_sync;
      feed_d.chan1_clock  = internal_horiz_sync;
      feed_d.chan1_reset  = ~internal_vert_sync;
      feed_d.chan_x_clock = internal_horiz_sync;
      feed_d.chan_x_reset = internal_horiz_sync;
      feed_d.chan_y_clock = generated_vert_sync;
      feed_d.chan_y_reset = generated_vert_sync;
    end else begin
      feed_d.frt_a        = timer_pins.frt_a;
      feed_d.frt_b        = timer_pins.frt_b;
      feed_d.frt_c        = timer_pins.frt_c;
      feed_d.frt_d        = timer_pins.frt_d;
      feed_d.chan1_clock  = timer_pins.chan1_event_input;
      feed_d.chan1_reset  = timer_pins.chan1_event_input;
      feed_d.chan_x_clock = timer_pins.chan_x_event_input;
      feed_d.chan_x_reset = timer_pins.chan_x_event_input;
      feed_d.chan_y_clock = timer_pins.chan_y_event_input;
      feed_d.chan_y_reset = timer_pins.chan_y_event_input;
    end
  end

  // Registered feed costs one cycle of latency on every timer input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_feed_q          <= '0;
      internal_horiz_sync_q <= 1'b0;
      internal_vert_sync_q  <= 1'b0;
    end else if (clk_en) begin
      timer_feed_q          <= feed_d;
      internal_horiz_sync_q <= internal_horiz_sync;
      internal_vert_sync_q  <= internal_vert_sync;
    end
  end

  // Software-writable control bits; the start bit is mirrored from the capture unit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl_q[mode_hi_bit:conn_en_bit] <= avs_writedata[mode_hi_bit:conn_en_bit];
      ctrl_q[inv_field_msb:0]         <= avs_writedata[inv_field_msb:0];
    end
  end

  // Remembers that the last control read saw the start bit at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_zero_q <= 1'b0;
    end else if (rd_ctrl) begin
      read_zero_q <= ~busy;
    end else if (wr_ctrl) begin
      read_zero_q <= 1'b0;
    end
  end

  pulse_capture u_capture (
    .clk               (clk),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .arm               (arm),
    .reset_in          (internal_horiz_sync_q),
    .timer_count_value (timer_count_value),
    .busy_q            (busy),
    .rise_capture_q    (rise_cap),
    .fall_capture_q    (fall_cap)
  );

  // One wait cycle per access; answer on the second edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= unmapped_rd;
    end else if (req & avs_read) begin
      unique case (avs_address)
        ctrl_addr:         avs_readdata <= {24'h00_0000, ctrl_q[mode_hi_bit:conn_en_bit],
                                            busy, ctrl_q[inv_field_msb:0]};
        rise_capture_addr: avs_readdata <= {24'h00_0000, rise_cap};
        fall_capture_addr: avs_readdata <= {24'h00_0000, fall_cap};
        status_addr:       avs_readdata <= {24'h00_0000, 7'h00, busy};
      endcase
    end
  end

endmodule

// ===== sync_input_select_capture_asserts.sv
`timescale 1ns/1ps
module sync_input_select_capture_asserts
  import sync_input_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Bus
  input wire logic [1:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and timers
  input wire sync_pins_t  sync_pins,
  input wire timer_pins_t timer_pins,
  input wire logic        chan1_compare_output,
  input wire logic        generated_vert_sync,
  input wire timer_feed_t timer_feed_q,
  input wire logic        internal_horiz_sync_q,
  input wire logic        internal_vert_sync_q
);
  logic [2:0]  md_q;
  logic [1:0]  wr_q;
  logic        quiet, ih_c, iv_c, en_q;
  timer_feed_t ex_c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of mode and enable; checks wait until a write has settled
  always_ff @(posedge clk) begin
    if (!rst_n) md_q <= 3'h0;
    else if (avs_write && !avs_waitrequest && avs_address == ctrl_addr) md_q <= avs_writedata[7:5];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) wr_q <= 2'h3;
    else wr_q <= {wr_q[0], avs_write};
  end
  // A frozen cycle breaks the one-cycle link between pins and feeds
  always_ff @(posedge clk) begin
    if (!rst_n) en_q <= 1'b0;
    else en_q <= clk_en;
  end
  assign quiet = !avs_write && wr_q == 2'h0 && en_q;
  always_comb begin
    ih_c = md_q[2] ? sync_pins[5] : (md_q[1] ? sync_pins[3] : sync_pins[2]);
    iv_c = (md_q[2:1] == 2'h3) ? sync_pins[4] : (md_q[2:1] == 2'h0 ? sync_pins[1] : sync_pins[0]);
    ex_c = md_q[0] ? {iv_c, chan1_compare_output, sync_pins[1], ih_c, ih_c, !iv_c, ih_c, ih_c,
                      generated_vert_sync, generated_vert_sync}
                   : {timer_pins[6:3], {2{timer_pins[2]}}, {2{timer_pins[1]}}, {2{timer_pins[0]}}};
  end
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_ihs; quiet |-> internal_horiz_sync_q == $past(ih_c); endproperty
  property p_ivs; quiet |-> internal_vert_sync_q == $past(iv_c); endproperty
  property p_norm; quiet && !md_q[0] |-> timer_feed_q == $past(ex_c); endproperty
  property p_sync; quiet && md_q[0] |-> timer_feed_q == $past(ex_c); endproperty
  property p_xrst; quiet && md_q[0] |-> timer_feed_q.chan_x_reset == internal_horiz_sync_q;
  endproperty
  property p_c1inv; quiet && md_q[0] |-> timer_feed_q.chan1_reset != internal_vert_sync_q;
  endproperty
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> s_ack; endproperty
  property p_rdhi; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  property p_frz;
    !clk_en |=> $stable(timer_feed_q) && $stable(internal_horiz_sync_q)
                && $stable(internal_vert_sync_q) && $stable(avs_waitrequest);
  endproperty
  a_ihs: assert property (p_ihs) else $error("horizontal sync route wrong");
  a_ivs: assert property (p_ivs) else $error("vertical sync route wrong");
  a_norm: assert property (p_norm) else $error("normal feed wrong");
  a_sync: assert property (p_sync) else $error("sync feed wrong");
  a_xrst: assert property (p_xrst) else $error("channel x reset not horizontal");
  a_c1inv: assert property (p_c1inv) else $error("channel 1 reset not inverted");
  a_wait: assert property (p_wait) else $error("bus answer late");
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
  a_frz: assert property (p_frz) else $error("state moved while clock enable low");
endmodule

// ===== sync_source_model.sv
`timescale 1ns/1ps
module sync_source_model
  import sync_input_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Far side
  output sync_pins_t  sync_pins,
  output timer_pins_t timer_pins,
  output logic        chan1_compare_output,
  output logic        generated_vert_sync,
  output logic [7:0]  timer_count_value
);
  logic [7:0] cnt_q;
  // Binary count gives each sync pin a fixed pulse width: 32, 16, 8, 4, 2, 1
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign sync_pins            = sync_pins_t'(cnt_q[5:0]);
  assign timer_pins           = timer_pins_t'(~cnt_q[6:0]);
  assign chan1_compare_output = cnt_q[6];
  assign generated_vert_sync  = cnt_q[7];
  assign timer_count_value    = cnt_q;
endmodule

// ===== sync_input_select_capture_tb.sv
`timescale 1ns/1ps
module sync_input_select_capture_tb;
  import sync_input_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic        avs_waitrequest, chan1_compare_output, generated_vert_sync;
  logic        internal_horiz_sync_q, internal_vert_sync_q;
  logic [7:0]  timer_count_value;
  sync_pins_t  sync_pins;
  timer_pins_t timer_pins;
  timer_feed_t timer_feed_q;
  int          n_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  sync_source_model u_sync_source_model (.clk, .rst_n, .sync_pins, .timer_pins,
    .chan1_compare_output, .generated_vert_sync, .timer_count_value);
  sync_input_select_capture u_sync_input_select_capture (.clk, .rst_n, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sync_pins,
    .timer_pins, .chan1_compare_output, .generated_vert_sync, .timer_count_value,
    .timer_feed_q, .internal_horiz_sync_q, .internal_vert_sync_q);
  task finish_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      $display("BAD %0t %s", $time, m);
      n_errors++;
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases
  task bus(input bit w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    chk(n < 50, "no bus answer");
  endtask
  task t_reset;
    logic [31:0] q;
    bus(0, ctrl_addr, 32'h0000_0000, q);
    chk(q[7:0] === ctrl_reset, "ctrl reset value");
  endtask
  // Arms after a zero read and checks the measured width of the selected pin
  task t_arm(input logic [1:0] m, input logic [7:0] width);
    logic [31:0] q, r;
    int n;
    bus(1, ctrl_addr, {24'h00_0000, m, m[0], 5'h00}, q);
    bus(0, ctrl_addr, 32'h0000_0000, q);
    bus(1, ctrl_addr, {24'h00_0000, m, m[0], 5'h10}, q);
    bus(0, status_addr, 32'h0000_0000, q);
    chk(q[0] === 1'b1, "capture not armed");
    n = 0;
    do begin
      bus(0, status_addr, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk(n < 100, "capture never finished");
    bus(0, ctrl_addr, 32'h0000_0000, q);
    chk(q[7:0] === {m, m[0], 5'h00}, "start bit not cleared");
    bus(0, rise_capture_addr, 32'h0000_0000, r);
    bus(0, fall_capture_addr, 32'h0000_0000, q);
    chk(q[7:0] - r[7:0] === width, "pulse width");
    // Pin rises at count width; one register stage on the internal sync puts the capture one count later
    chk((r[7:0] & ((width << 1) - 8'h01)) === width + 8'h01, "rise capture point");
  endtask
  task t_noarm;
    logic [31:0] q, r, f;
    bus(0, rise_capture_addr, 32'h0000_0000, r);
    bus(0, fall_capture_addr, 32'h0000_0000, f);
    bus(1, ctrl_addr, 32'h0000_00C0, q);
    bus(1, ctrl_addr, 32'h0000_00D0, q);
    bus(0, status_addr, 32'h0000_0000, q);
    chk(q[0] === 1'b0, "armed without zero read");
    repeat (70) @(posedge clk);
    bus(0, rise_capture_addr, 32'h0000_0000, q);
    chk(q === r, "capture moved while idle");
    bus(0, fall_capture_addr, 32'h0000_0000, q);
    chk(q === f, "fall capture moved while idle");
  endtask
  // Clock enable low must hold the timer feed and both internal syncs although the pins keep moving
  task t_freeze;
    timer_feed_t f;
    logic h, v;
    clk_en <= 1'b0;
    @(posedge clk);
    f = timer_feed_q;
    h = internal_horiz_sync_q;
    v = internal_vert_sync_q;
    repeat (40) @(posedge clk);
    chk(timer_feed_q === f, "feed moved while frozen");
    chk(internal_horiz_sync_q === h, "horizontal moved while frozen");
    chk(internal_vert_sync_q === v, "vertical moved while frozen");
    clk_en <= 1'b1;
    @(posedge clk);
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_arm(2'h0, 8'h04);
    t_arm(2'h1, 8'h08);
    t_arm(2'h2, 8'h20);
    t_arm(2'h3, 8'h20);
    t_noarm;
    t_freeze;
    finish_test;
  end
endmodule
bind sync_input_select_capture sync_input_select_capture_asserts
  u_sync_input_select_capture_asserts (.clk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .sync_pins, .timer_pins,
  .chan1_compare_output, .generated_vert_sync, .timer_feed_q, .internal_horiz_sync_q,
  .internal_vert_sync_q);
